// ### verilog/tlpo_top.v
// totalizer, pulse generator and 4..20 mA loop setpoint of the meter output
// assumes all inputs come from logic on clock; the analog stage follows loop_ua_q
`timescale 1ns/1ps
`include "tlpo_map.vh"

// Contract
// - exactly one measurand and unit drives the loop output at any time
// - after reset or defaults load the loop unit is flow in m3n/h
// - zero maps to 4 mA, span to 20 mA, linearly
// - a negative zero gives bidirectional output, reverse flow below midpoint
// - single-direction defaults zero 0 percent, span 100 percent, idle 4 mA
// - bidirectional defaults zero -100 percent, span 100 percent, idle 12 mA
// - pulse mode emits one 0 to 20 mA pulse per interval of volume
// - pulses come no faster than one per 2 seconds, except after a totalizer write or pulse mode exit ends the gap early
// - interval too small for the rate limit gives a steady 20 mA level
// - negative flow decrements the totalizer and makes no pulse
// - after reverse flow, pulses resume only once the volume is regained
// - default interval 0.1, 0.2 or 1 m3n by pipe diameter 25/45 mm
// - a host write to the totalizer clears it to zero plus any delta arriving in the same cycle
module tlpo_top #(
	parameter GAP_CYC  = `TLPO_PULSE_GAP_MS * `TLPO_CLK_KHZ,
	parameter HIGH_CYC = `TLPO_PULSE_HIGH_MS * `TLPO_CLK_KHZ
) (
	input  wire         clock,
	input  wire         reset,
	input  wire         clock_enable,
	input  wire [319:0] meas_flat,
	input  wire         mode_pulse,
	input  wire         bidir,
	input  wire         defaults_load,
	input  wire         cfg_load,
	input  wire [3:0]   unit_in,
	input  wire [31:0]  zero_in,
	input  wire [31:0]  span_in,
	input  wire [31:0]  interval_in,
	input  wire [15:0]  diameter_mm,
	input  wire         vol_valid,
	input  wire [31:0]  vol_delta,
	input  wire         total_write,
	output reg  [31:0]  total_q,
	output reg  [15:0]  loop_ua_q,
	output reg          pulse_q,
	output reg          saturated_q,
	output reg  [3:0]   unit_q
);

	// ********************
	// decoding helpers
	// ********************
	// codes above the last unit fall back to flow per second
	function [3:0] unit_fix;
		input [3:0] u;
		begin
			unit_fix = (u > `TLPO_UNIT_LAST) ? `TLPO_UNIT_MPS : u;
		end
	endfunction

	function [31:0] ivl_for_dia;
		input [15:0] d;
		begin
			if (d < `TLPO_DIA_SMALL_MM)
				ivl_for_dia = `TLPO_IVL_SMALL;
			else if (d <= `TLPO_DIA_LARGE_MM)
				ivl_for_dia = `TLPO_IVL_MID;
			else
				ivl_for_dia = `TLPO_IVL_LARGE;
		end
	endfunction

	// ********************
	// configuration
	// ********************
	reg  [31:0] zero_q;
	reg  [31:0] span_q;
	reg  [31:0] ivl_q;
	reg         dflt_pend_q;

	// reset takes constants only; diameter defaults follow one cycle later
	always @(posedge clock) begin
		if (reset) begin
			unit_q      <= `TLPO_UNIT_M3H;
			zero_q      <= `TLPO_ZERO_RST;
			span_q      <= `TLPO_FULL_SCALE;
			ivl_q       <= `TLPO_IVL_LARGE;
			dflt_pend_q <= 1'b1;
		end else if (clock_enable) begin
			dflt_pend_q <= 1'b0;
			if (dflt_pend_q || defaults_load) begin
				unit_q <= `TLPO_UNIT_M3H;
				zero_q <= bidir ? (32'h00000000 - `TLPO_FULL_SCALE) : `TLPO_ZERO_RST;
				span_q <= `TLPO_FULL_SCALE;
				ivl_q  <= ivl_for_dia(diameter_mm);
			end else if (cfg_load) begin
				unit_q <= unit_fix(unit_in);
				zero_q <= zero_in;
				span_q <= span_in;
				ivl_q  <= interval_in;
			end
		end
	end

	// ********************
	// measurand selection
	// ********************
	wire [31:0] meas_w [0:`TLPO_UNIT_COUNT-1];
	genvar gi;
	generate
		for (gi = 0; gi < `TLPO_UNIT_COUNT; gi = gi + 1) begin : g_meas
			assign meas_w[gi] = meas_flat[gi*32 +: 32];
		end
	endgenerate
	wire [31:0] sel_val = meas_w[unit_q];

	// ********************
	// linear scaling, signed arithmetic widened by one bit
	// ********************
	wire [32:0] diff  = {sel_val[31], sel_val} - {zero_q[31], zero_q};
	wire [32:0] den   = {span_q[31], span_q} - {zero_q[31], zero_q};
	wire        below = diff[32] || (diff == 33'h000000000);
	wire        above = !den[32] && !below && (diff >= den);
	wire        bad   = den[32] || (den == 33'h000000000);
	wire [47:0] num   = {15'h0000, diff} * `TLPO_UA_RANGE;
	wire [47:0] quo;
	wire        div_done;
	wire        div_busy;

	tlpo_div #(
		.NW (48),
		.DW (33)
	) u_div (
		.clock        (clock),
		.reset        (reset),
		.clock_enable (clock_enable),
		.start        (!mode_pulse && !below && !above && !bad),
		.num          (num),
		.den          (den),
		.quo_q        (quo),
		.done_q       (div_done),
		.busy         (div_busy)
	);

	// ********************
	// totalizer and pulse reference
	// ********************
	reg  [31:0] ref_q;
	wire [31:0] acc = total_q - ref_q;
	// a negative backlog never pulses; it must be regained first
	wire        due = !acc[31] && (acc >= ivl_q) && (ivl_q != 32'h00000000);
	wire        backlog = !acc[31] && ((acc >> 1) >= ivl_q);
	reg  [31:0] gap_q;
	reg  [31:0] high_q;

	// delta arriving with a clear is kept so no volume is lost
	always @(posedge clock) begin
		if (reset) begin
			total_q <= 32'h00000000;
			ref_q   <= 32'h00000000;
		end else if (clock_enable) begin
			if (total_write) begin
				total_q <= vol_valid ? vol_delta : 32'h00000000;
				ref_q   <= 32'h00000000;
			end else begin
				if (vol_valid)
					total_q <= total_q + vol_delta;
				if (mode_pulse && due && (gap_q == 32'h00000000))
					ref_q <= ref_q + ivl_q;
			end
		end
	end

	// ********************
	// pulse timing
	// ********************
	// gap counter spans pulse start to pulse start, the high time sits inside it
	always @(posedge clock) begin
		if (reset) begin
			gap_q       <= 32'h00000000;
			high_q      <= 32'h00000000;
			pulse_q     <= 1'b0;
			saturated_q <= 1'b0;
		end else if (clock_enable) begin
			saturated_q <= mode_pulse && backlog && (gap_q != 32'h00000000);
			if (!mode_pulse || total_write) begin
				gap_q   <= 32'h00000000;
				high_q  <= 32'h00000000;
				pulse_q <= 1'b0;
			end else if (due && (gap_q == 32'h00000000)) begin
				gap_q   <= GAP_CYC - 1;
				high_q  <= HIGH_CYC - 1;
				pulse_q <= 1'b1;
			end else begin
				if (gap_q != 32'h00000000)
					gap_q <= gap_q - 32'h00000001;
				if (high_q != 32'h00000000)
					high_q <= high_q - 32'h00000001;
				else
					pulse_q <= 1'b0;
			end
		end
	end

	// ********************
	// loop current output
	// ********************
	// clamps outside zero..span keep the loop inside 4..20 mA
	always @(posedge clock) begin
		if (reset) begin
			loop_ua_q <= `TLPO_UA_ZERO;
		end else if (clock_enable) begin
			if (mode_pulse)
				loop_ua_q <= (pulse_q || saturated_q) ? `TLPO_UA_SPAN : `TLPO_UA_OFF;
			else if (bad || below)
				loop_ua_q <= `TLPO_UA_ZERO;
			else if (above)
				loop_ua_q <= `TLPO_UA_SPAN;
			else if (div_done)
				loop_ua_q <= `TLPO_UA_ZERO + quo[15:0];
		end
	end

endmodule

// ### verilog/tlpo_map.vh
// constants of the totalizer pulse and current loop output block
// assumes inclusion by bare name from every design file that needs it
`ifndef TLPO_MAP_VH
`define TLPO_MAP_VH

// ********************
// clock and timing
// ********************
`define TLPO_CLK_KHZ       100000
`define TLPO_PULSE_GAP_MS  2000
`define TLPO_PULSE_HIGH_MS 500

// ********************
// loop current levels, microamps
// ********************
`define TLPO_UA_OFF        16'h0000
`define TLPO_UA_ZERO       16'h0FA0
`define TLPO_UA_SPAN       16'h4E20
`define TLPO_UA_RANGE      48'h000000003E80

// ********************
// unit codes of the loop selector
// ********************
`define TLPO_UNIT_MPS      4'h0
`define TLPO_UNIT_M3H      4'h1
`define TLPO_UNIT_LAST     4'h9
`define TLPO_UNIT_COUNT    10

// ********************
// reset values and defaults
// ********************
`define TLPO_FULL_SCALE    32'h00002710
`define TLPO_ZERO_RST      32'h00000000
`define TLPO_DIA_SMALL_MM  16'h0019
`define TLPO_DIA_LARGE_MM  16'h002D
`define TLPO_IVL_SMALL     32'h00000064
`define TLPO_IVL_MID       32'h000000C8
`define TLPO_IVL_LARGE     32'h000003E8

`endif

// ### verilog/tlpo_div.v
// sequential unsigned divider, one quotient bit per enabled cycle
// assumes the caller holds num and den stable from start until done
`timescale 1ns/1ps

module tlpo_div #(
	parameter NW = 48,
	parameter DW = 33
) (
	input  wire          clock,
	input  wire          reset,
	input  wire          clock_enable,
	input  wire          start,
	input  wire [NW-1:0] num,
	input  wire [DW-1:0] den,
	output reg  [NW-1:0] quo_q,
	output reg           done_q,
	output wire          busy
);

	// sized copy of the width, so the loop count is a plain part-select
	localparam [31:0] NW_W = NW;

	reg  [NW-1:0] shf_q;
	reg  [DW:0]   rem_q;
	reg  [6:0]    cnt_q;
	reg           run_q;
	wire [DW:0]   trial;
	wire          fits;

	assign busy  = run_q;
	assign trial = {rem_q[DW-1:0], shf_q[NW-1]};
	assign fits  = (trial >= {1'b0, den});

	// ********************
	// long division loop
	// ********************
	always @(posedge clock) begin
		if (reset) begin
			shf_q  <= {NW{1'b0}};
			rem_q  <= {(DW+1){1'b0}};
			cnt_q  <= 7'h00;
			run_q  <= 1'b0;
			quo_q  <= {NW{1'b0}};
			done_q <= 1'b0;
		end else if (clock_enable) begin
			done_q <= 1'b0;
			if (!run_q && start) begin
				shf_q <= num;
				rem_q <= {(DW+1){1'b0}};
				cnt_q <= NW_W[6:0];
				run_q <= 1'b1;
			end else if (run_q) begin
				// quotient bits shift in where numerator bits leave
				rem_q <= fits ? (trial - {1'b0, den}) : trial;
				shf_q <= {shf_q[NW-2:0], fits};
				cnt_q <= cnt_q - 7'h01;
				if (cnt_q == 7'h01) begin
					run_q  <= 1'b0;
					done_q <= 1'b1;
					quo_q  <= {shf_q[NW-2:0], fits};
				end
			end
		end
	end

endmodule

// ### test/tlpo_top_chk.sv
// port checker of the meter output block
// assumes binding onto tlpo_top with one clock and a synchronous high reset
`timescale 1ns/1ps
module tlpo_chk #(
	parameter GAP_CYC  = 200000000,
	parameter HIGH_CYC = 50000000
) (
	input wire        clock,
	input wire        reset,
	input wire        clock_enable,
	input wire        mode_pulse,
	input wire        defaults_load,
	input wire        cfg_load,
	input wire [3:0]  unit_in,
	input wire        vol_valid,
	input wire [31:0] vol_delta,
	input wire        total_write,
	input wire [31:0] total_q,
	input wire [15:0] loop_ua_q,
	input wire        pulse_q,
	input wire        saturated_q,
	input wire [3:0]  unit_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// ****************
	// helper counters
	// ****************
	reg [31:0] gap_q;
	reg [6:0]  age_q;
	// cycles since a pulse; an abort lets the next one come early
	always @(posedge clock) begin
		if (reset || total_write || !mode_pulse)
			gap_q <= GAP_CYC;
		else if ($rose(pulse_q))
			gap_q <= 32'h1;
		else if (clock_enable && gap_q < GAP_CYC)
			gap_q <= gap_q + 32'h1;
	end
	// loop mode age, long enough for one divider pass
	always @(posedge clock) begin
		if (mode_pulse)
			age_q <= 7'h00;
		else if (reset)
			age_q <= 7'h40;
		else if (age_q < 7'h40)
			age_q <= age_q + 7'h01;
	end
	// ****************
	// properties
	// ****************
	property p_rst; $fell(reset) |-> unit_q == 4'h1 && total_q == 32'h0 && !pulse_q; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_unit; cfg_load && clock_enable && !defaults_load && !$past(reset)
		|=> unit_q == ($past(unit_in) > 4'h9 ? 4'h0 : $past(unit_in)); endproperty
	a_unit: assert property (p_unit) else $error("loop unit not taken");
	property p_dflt; defaults_load && clock_enable |=> unit_q == 4'h1; endproperty
	a_dflt: assert property (p_dflt) else $error("default unit wrong");
	property p_clr; total_write && !vol_valid && clock_enable |=> total_q == 32'h0; endproperty
	a_clr: assert property (p_clr) else $error("totalizer not cleared");
	property p_acc; vol_valid && !total_write && clock_enable
		|=> total_q == $past(total_q) + $past(vol_delta); endproperty
	a_acc: assert property (p_acc) else $error("totalizer sum wrong");
	property p_gap; $rose(pulse_q) |-> gap_q >= GAP_CYC; endproperty
	a_gap: assert property (p_gap) else $error("pulses too close");
	// high for exactly HIGH_CYC samples after the rise; an abort resets the count
	property p_high; gap_q <= HIGH_CYC |-> pulse_q == (gap_q < HIGH_CYC); endproperty
	a_high: assert property (p_high) else $error("pulse too short");
	property p_amp; clock_enable && mode_pulse && (pulse_q || saturated_q)
		|=> loop_ua_q == 16'h4E20; endproperty
	a_amp: assert property (p_amp) else $error("pulse level wrong");
	property p_rng; age_q == 7'h40 |-> loop_ua_q >= 16'h0FA0 && loop_ua_q <= 16'h4E20; endproperty
	a_rng: assert property (p_rng) else $error("loop out of range");
	c_pulse: cover property ($rose(pulse_q));
	c_sat: cover property ($rose(saturated_q));
	c_cfg: cover property (cfg_load && !mode_pulse);
endmodule

bind tlpo_top tlpo_chk #(.GAP_CYC(GAP_CYC), .HIGH_CYC(HIGH_CYC)) chk (
	.clock         (clock),
	.reset         (reset),
	.clock_enable  (clock_enable),
	.mode_pulse    (mode_pulse),
	.defaults_load (defaults_load),
	.cfg_load      (cfg_load),
	.unit_in       (unit_in),
	.vol_valid     (vol_valid),
	.vol_delta     (vol_delta),
	.total_write   (total_write),
	.total_q       (total_q),
	.loop_ua_q     (loop_ua_q),
	.pulse_q       (pulse_q),
	.saturated_q   (saturated_q),
	.unit_q        (unit_q)
);

// ### test/tlpo_loop_rx.sv
// current input of the receiving control system
// assumes it samples the loop current on the block clock
`timescale 1ns/1ps
module tlpo_loop_rx (
	input  wire        clock,
	input  wire        reset,
	input  wire [15:0] loop_ua,
	output reg  [15:0] pulse_cnt_q
);
	reg hi_q;
	// a pulse is an upward crossing of mid-range, as a threshold input sees it
	always @(posedge clock) begin
		hi_q <= loop_ua >= 16'h2EE0;
		if (reset)
			pulse_cnt_q <= 16'h0000;
		else if (loop_ua >= 16'h2EE0 && !hi_q)
			pulse_cnt_q <= pulse_cnt_q + 16'h0001;
	end
endmodule

// ### test/tlpo_top_tb.sv
// self-checking bench of the meter output block
// assumes shortened pulse timing: gap 20 cycles, high 5 cycles
`timescale 1ns/1ps
module tlpo_top_tb;
	reg          clock = 0;
	reg          reset = 1;
	reg          clock_enable = 1;
	reg  [319:0] meas_flat = {10{32'h7FFFFFFF}};
	reg          mode_pulse = 1, bidir = 0, defaults_load = 0, cfg_load = 0;
	reg  [3:0]   unit_in = 4'h1;
	reg  [31:0]  zero_in = 32'h0, span_in = 32'h2710, interval_in = 32'h1;
	reg  [15:0]  diameter_mm = 16'h0018;
	reg          vol_valid = 0, total_write = 0;
	reg  [31:0]  vol_delta = 32'h0;
	wire [31:0]  total_q;
	wire [15:0]  loop_ua_q, pulse_cnt_q;
	wire         pulse_q, saturated_q;
	wire [3:0]   unit_q;
	int          num_errors = 0, tests_run = 0, i;
	reg  [0:3][15:0] dia = {16'h0018, 16'h0019, 16'h002D, 16'h002E};
	reg  [0:3][31:0] ivl = {32'h64, 32'hC8, 32'hC8, 32'h3E8};
	tlpo_top #(.GAP_CYC(20), .HIGH_CYC(5)) uut (
		.clock         (clock),
		.reset         (reset),
		.clock_enable  (clock_enable),
		.meas_flat     (meas_flat),
		.mode_pulse    (mode_pulse),
		.bidir         (bidir),
		.defaults_load (defaults_load),
		.cfg_load      (cfg_load),
		.unit_in       (unit_in),
		.zero_in       (zero_in),
		.span_in       (span_in),
		.interval_in   (interval_in),
		.diameter_mm   (diameter_mm),
		.vol_valid     (vol_valid),
		.vol_delta     (vol_delta),
		.total_write   (total_write),
		.total_q       (total_q),
		.loop_ua_q     (loop_ua_q),
		.pulse_q       (pulse_q),
		.saturated_q   (saturated_q),
		.unit_q        (unit_q)
	);
	tlpo_loop_rx rx (
		.clock       (clock),
		.reset       (reset),
		.loop_ua     (loop_ua_q),
		.pulse_cnt_q (pulse_cnt_q)
	);
	// 100 MHz clock
	always #5 clock = ~clock;
	// ****************
	// tasks
	// ****************
	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0s exp %h got %h", nm, exp, seen);
		end
	endtask
	// one-cycle strobe of defaults, config and totalizer write
	task strobe(input [2:0] k);
		@(posedge clock);
		{defaults_load, cfg_load, total_write} <= k;
		@(posedge clock);
		{defaults_load, cfg_load, total_write} <= 3'h0;
	endtask
	task vol(input [31:0] d);
		@(posedge clock);
		vol_valid <= 1;
		vol_delta <= d;
		@(posedge clock);
		vol_valid <= 0;
	endtask
	// other slots sit far above span, so a wrong selection clamps high
	task lp(input [2:0] k, input b, input [3:0] u, input [31:0] z, s, v,
		input [3:0] eu, input [31:0] e);
		meas_flat <= {10{32'h7FFFFFFF}};
		bidir <= b;
		unit_in <= u;
		zero_in <= z;
		span_in <= s;
		strobe(k);
		meas_flat[eu*32 +: 32] <= v;
		cyc(120);
		chk("unit", unit_q, eu);
		chk("loop", loop_ua_q, e);
	endtask
	task give_verdict;
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ****************
	// tests
	// ****************
	initial begin
		cyc(10);
		reset <= 0;
		cyc(1);
		chk("unit", unit_q, 32'h1);
		chk("total", total_q, 32'h0);
		// default interval per diameter, restarted by a clear
		for (i = 0; i < 4; i++) begin
			cyc(25);
			diameter_mm <= dia[i];
			strobe(3'h4);
			strobe(3'h1);
			cyc(2);
			chk("total", total_q, 32'h0);
			vol(ivl[i] - 32'h1);
			cyc(4);
			chk("early", pulse_q, 32'h0);
			chk("low", loop_ua_q, 32'h0);
			vol(32'h1);
			cyc(3);
			chk("pulse", pulse_q, 32'h1);
		end
		cyc(30);
		vol(32'hFFFFFC18);
		cyc(2);
		chk("total", total_q, 32'h0);
		vol(32'h3E8);
		cyc(3);
		chk("regain", pulse_q, 32'h0);
		vol(32'h3E8);
		cyc(3);
		chk("resume", pulse_q, 32'h1);
		cyc(30);
		chk("count", pulse_cnt_q, 32'h5);
		// a low enable must swallow a volume strobe
		clock_enable <= 0;
		vol(32'h5);
		cyc(2);
		chk("frozen", total_q, 32'h7D0);
		clock_enable <= 1;
		interval_in <= 32'h1;
		strobe(3'h3);
		vol(32'hA);
		cyc(12);
		chk("steady", saturated_q, 32'h1);
		chk("level", loop_ua_q, 32'h4E20);
		mode_pulse <= 0;
		lp(3'h4, 0, 4'h0, 32'h0, 32'h0, 32'h0, 4'h1, 32'h0FA0);
		lp(3'h4, 0, 4'h0, 32'h0, 32'h0, 32'h1388, 4'h1, 32'h2EE0);
		lp(3'h4, 1, 4'h0, 32'h0, 32'h0, 32'h0, 4'h1, 32'h2EE0);
		lp(3'h4, 1, 4'h0, 32'h0, 32'h0, 32'hFFFFEC78, 4'h1, 32'h1F40);
		lp(3'h2, 0, 4'h8, 32'h64, 32'hC8, 32'h96, 4'h8, 32'h2EE0);
		lp(3'h2, 0, 4'hC, 32'hFFFFFFCE, 32'h32, 32'h19, 4'h0, 32'h3E80);
		give_verdict;
	end
	// watchdog well beyond the expected run of about 1000 cycles
	initial begin
		#100000;
		num_errors++;
		give_verdict;
	end
endmodule
